// ### rtl/edas_pkg.sv
// Constants shared by the external data access stretch block.
// Assumes one 200 MHz oscillator clock and an 8-bit special register bus.
package edas_pkg;

    // ============
    // Register offsets on the special register bus
    // ============
    localparam logic [7:0] ADDR_PTR0_LOW  = 8'h82;
    localparam logic [7:0] ADDR_PTR0_HIGH = 8'h83;
    localparam logic [7:0] ADDR_PTR1_LOW  = 8'h84;
    localparam logic [7:0] ADDR_PTR1_HIGH = 8'h85;
    localparam logic [7:0] ADDR_PTR_SEL   = 8'h86;
    localparam logic [7:0] ADDR_CLK_CTRL  = 8'h8E;
    localparam logic [7:0] ADDR_PORT2     = 8'hA0;
    localparam logic [7:0] ADDR_STATUS    = 8'hD1;

    // ============
    // Field positions and reset values
    // ============
    localparam int         STRETCH_MSB     = 2;
    localparam int         PTR_SEL_BIT     = 0;
    localparam int         STAT_BUSY_BIT   = 0;
    localparam int         STAT_INT_BIT    = 1;
    localparam logic [7:0] CLK_CTRL_RESET  = 8'h01;
    localparam logic [7:0] PORT2_RESET     = 8'hFF;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;

    // ============
    // Cycle counts
    // ============
    localparam logic [1:0] CLKS_PER_MC_M1  = 2'h3;
    localparam logic [4:0] FETCH_LAST      = 5'h03;
    localparam logic [4:0] FETCH_STRB_FRST = 5'h01;
    localparam logic [4:0] FETCH_STRB_LAST = 5'h02;
    localparam logic [4:0] SETUP_FAST      = 5'h01;
    localparam logic [4:0] SETUP_SLOW      = 5'h02;
    localparam logic [4:0] WIDTH_FAST      = 5'h02;
    localparam logic [15:0] ONCHIP_BYTES   = 16'h0000;

    typedef enum logic [1:0] {
        EDAS_IDLE,
        EDAS_FETCH,
        EDAS_DATA
    } edas_state_t;

endpackage : edas_pkg

// ### rtl/edas_phase_gen.sv
// Machine cycle phase divider for the external data access block.
// Assumes a free running oscillator clock and an active low async reset.
module edas_phase_gen
    import edas_pkg::*;
(
    input  wire logic       clk,       // Oscillator clock.
    input  wire logic       resetn,    // Asynchronous reset, active low.
    output logic [1:0]      phase,     // Clock index inside machine cycle.
    output logic            lastClk    // High in the fourth clock.
);

    // ============
    // Four-clock phase counter
    // ============
    // The counter runs free so every access aligns to one grid.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase <= 2'h0;
        end else if (phase == CLKS_PER_MC_M1) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // Registered so the flag lines up with phase three exactly.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lastClk <= 1'b0;
        end else begin
            lastClk <= (phase == (CLKS_PER_MC_M1 - 2'h1));
        end
    end

endmodule : edas_phase_gen

// ### rtl/edas_top.sv
// External data access controller with stretchable strobes.
// Assumes the core raises one request at a time while busy is low and
// that the external target meets the strobe width software selects.
//
// The plain strobed port is this design's own decision.
module edas_top
    import edas_pkg::*;
(
    input  wire logic        clk,          // Oscillator clock, 200 MHz.
    input  wire logic        resetn,       // Async reset, active low.
    input  wire logic [7:0]  regAddr,      // Register address.
    input  wire logic [7:0]  regWdata,     // Register write data.
    input  wire logic        regWrite,     // Register write strobe.
    input  wire logic        regRead,      // Register read strobe.
    output logic      [7:0]  regRdata,     // Read data, one cycle later.
    input  wire logic        reqValid,     // Access request pulse.
    input  wire logic        reqMove,      // One: fetch plus data move.
    input  wire logic        reqWriteDir,  // One: data move is a write.
    input  wire logic        reqIndirect,  // One: working register address.
    input  wire logic [15:0] reqPc,        // Fetch address.
    input  wire logic [7:0]  reqRi,        // Working register value.
    input  wire logic [7:0]  reqWdata,     // Data to write.
    output logic             busy,         // Access in progress.
    output logic             done,         // Access finished pulse.
    output logic      [7:0]  fetchData,    // Fetched byte.
    output logic      [7:0]  readData,     // Byte read by a data move.
    output logic             internalHit,  // Last move hit on-chip range.
    output logic      [15:0] memAddr,      // External address pins.
    input  wire logic [7:0]  memDataIn,    // Data bus pins, input.
    output logic      [7:0]  memDataOut,   // Data bus pins, output.
    output logic             memDataOe,    // Data bus drive enable.
    output logic             memRdN,       // Read strobe, active low.
    output logic             memWrN,       // Write strobe, active low.
    output logic             memFetchN     // Fetch strobe, active low.
);

    // ============
    // Helper functions
    // ============
    // Clocks between window start and first strobe clock.
    function automatic logic [4:0] strobeSetup(input logic [2:0] s);
        strobeSetup = (s == 3'h0) ? SETUP_FAST : SETUP_SLOW;
    endfunction : strobeSetup

    // Strobe width in clocks.
    function automatic logic [4:0] strobeWidth(input logic [2:0] s);
        if (s == 3'h0) begin
            strobeWidth = WIDTH_FAST;
        end else begin
            strobeWidth = {s, 2'b00};
        end
    endfunction : strobeWidth

    // Last clock index of the data window.
    function automatic logic [4:0] windowLast(input logic [2:0] s);
        windowLast = {s, 2'b11};
    endfunction : windowLast

    // True while the strobe is active at a given window clock.
    function automatic logic inStrobe(input logic [4:0] c,
                                      input logic [2:0] s);
        inStrobe = (c >= strobeSetup(s)) &&
                   (c < strobeSetup(s) + strobeWidth(s));
    endfunction : inStrobe

    // ============
    // Declarations
    // ============
    logic [1:0]  phase;
    logic        lastClk;
    logic [7:0]  ptr0Low_q;
    logic [7:0]  ptr0High_q;
    logic [7:0]  ptr1Low_q;
    logic [7:0]  ptr1High_q;
    logic        ptrSel_q;
    logic [7:0]  clkCtrl_q;
    logic [7:0]  port2_q;
    logic [7:0]  dinMeta_q;
    logic [7:0]  dinSync_q;
    edas_state_t state_q;
    edas_state_t state_d;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    logic        finish;
    logic        pend_q;
    logic        move_q;
    logic        wrDir_q;
    logic        internal_q;
    logic [2:0]  stretch_q;
    logic [15:0] pc_q;
    logic [15:0] dataAddr_q;
    logic [7:0]  wdata_q;
    logic [15:0] reqDataAddr;
    logic        take;
    logic        dataExt;

    edas_phase_gen u_phase (
        .clk     (clk),
        .resetn  (resetn),
        .phase   (phase),
        .lastClk (lastClk)
    );

    // ============
    // Data bus input synchroniser
    // ============
    // Pins are asynchronous to the core, so two flops precede any use.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dinMeta_q <= BYTE_ZERO;
            dinSync_q <= BYTE_ZERO;
        end else begin
            dinMeta_q <= memDataIn;
            dinSync_q <= dinMeta_q;
        end
    end

    // ============
    // Register file writes
    // ============
    // Writes land at any time; an access in flight keeps its latched
    // stretch and address, so a change only affects later accesses.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ptr0Low_q  <= BYTE_ZERO;
            ptr0High_q <= BYTE_ZERO;
            ptr1Low_q  <= BYTE_ZERO;
            ptr1High_q <= BYTE_ZERO;
            ptrSel_q   <= 1'b0;
            clkCtrl_q  <= CLK_CTRL_RESET;
            port2_q    <= PORT2_RESET;
        end else if (regWrite) begin
            if (regAddr == ADDR_PTR0_LOW) begin
                ptr0Low_q <= regWdata;
            end else if (regAddr == ADDR_PTR0_HIGH) begin
                ptr0High_q <= regWdata;
            end else if (regAddr == ADDR_PTR1_LOW) begin
                ptr1Low_q <= regWdata;
            end else if (regAddr == ADDR_PTR1_HIGH) begin
                ptr1High_q <= regWdata;
            end else if (regAddr == ADDR_PTR_SEL) begin
                ptrSel_q <= regWdata[PTR_SEL_BIT];
            end else if (regAddr == ADDR_CLK_CTRL) begin
                clkCtrl_q <= regWdata;
            end else if (regAddr == ADDR_PORT2) begin
                port2_q <= regWdata;
            end
        end
    end

    // ============
    // Register file reads
    // ============
    // Unmapped addresses and unused select and status bits read as zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= BYTE_ZERO;
        end else if (regRead) begin
            if (regAddr == ADDR_PTR0_LOW) begin
                regRdata <= ptr0Low_q;
            end else if (regAddr == ADDR_PTR0_HIGH) begin
                regRdata <= ptr0High_q;
            end else if (regAddr == ADDR_PTR1_LOW) begin
                regRdata <= ptr1Low_q;
            end else if (regAddr == ADDR_PTR1_HIGH) begin
                regRdata <= ptr1High_q;
            end else if (regAddr == ADDR_PTR_SEL) begin
                regRdata <= {7'h00, ptrSel_q};
            end else if (regAddr == ADDR_CLK_CTRL) begin
                regRdata <= clkCtrl_q;
            end else if (regAddr == ADDR_PORT2) begin
                regRdata <= port2_q;
            end else if (regAddr == ADDR_STATUS) begin
                regRdata <= {6'h00, internal_q, busy};
            end else begin
                regRdata <= BYTE_ZERO;
            end
        end else begin
            regRdata <= BYTE_ZERO;
        end
    end

    // ============
    // Request capture
    // ============
    // Address source chosen at request time from the live registers.
    always_comb begin
        if (reqIndirect) begin
            reqDataAddr = {port2_q, reqRi};
        end else if (ptrSel_q) begin
            reqDataAddr = {ptr1High_q, ptr1Low_q};
        end else begin
            reqDataAddr = {ptr0High_q, ptr0Low_q};
        end
    end

    assign take = reqValid && !busy;

    // Request fields are frozen for the whole access.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            move_q     <= 1'b0;
            wrDir_q    <= 1'b0;
            stretch_q  <= CLK_CTRL_RESET[STRETCH_MSB:0];
            pc_q       <= 16'h0000;
            dataAddr_q <= 16'h0000;
            wdata_q    <= BYTE_ZERO;
            internal_q <= 1'b0;
        end else if (take) begin
            move_q     <= reqMove;
            wrDir_q    <= reqWriteDir;
            stretch_q  <= clkCtrl_q[STRETCH_MSB:0];
            pc_q       <= reqPc;
            dataAddr_q <= reqDataAddr;
            wdata_q    <= reqWdata;
            internal_q <= reqMove && (reqDataAddr < ONCHIP_BYTES);
        end
    end

    // Pending until the next machine cycle boundary; busy until done.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_q <= 1'b0;
            busy   <= 1'b0;
            done   <= 1'b0;
        end else begin
            pend_q <= take || (pend_q && (state_d == EDAS_IDLE));
            busy   <= take || (busy && !finish);
            done   <= finish;
        end
    end

    // ============
    // Access sequencer
    // ============
    // Fetch always takes one fixed machine cycle; the data window then
    // takes stretch plus one machine cycles, keeping the phase grid.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        finish  = 1'b0;
        case (state_q)
            EDAS_IDLE: begin
                if (pend_q && lastClk) begin
                    state_d = EDAS_FETCH;
                    cnt_d   = 5'h00;
                end
            end
            EDAS_FETCH: begin
                if (cnt_q == FETCH_LAST) begin
                    cnt_d = 5'h00;
                    if (move_q) begin
                        state_d = EDAS_DATA;
                    end else begin
                        state_d = EDAS_IDLE;
                        finish  = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            EDAS_DATA: begin
                if (cnt_q == windowLast(stretch_q)) begin
                    state_d = EDAS_IDLE;
                    cnt_d   = 5'h00;
                    finish  = 1'b1;
                end else begin
                    cnt_d = cnt_q + 5'h01;
                end
            end
            default: begin
                state_d = EDAS_IDLE;
                cnt_d   = 5'h00;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= EDAS_IDLE;
            cnt_q   <= 5'h00;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ============
    // Captured data
    // ============
    // Capture at the last window clock; the synchroniser lag means the
    // sampled pins are from two clocks earlier, inside the strobe.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fetchData   <= BYTE_ZERO;
            readData    <= BYTE_ZERO;
            internalHit <= 1'b0;
        end else begin
            if (state_q == EDAS_FETCH && cnt_q == FETCH_LAST) begin
                fetchData <= dinSync_q;
            end
            if (state_q == EDAS_DATA &&
                cnt_q == windowLast(stretch_q)) begin
                internalHit <= internal_q;
                if (!wrDir_q) begin
                    readData <= internal_q ? BYTE_ZERO : dinSync_q;
                end
            end
        end
    end

    // ============
    // Pin drivers
    // ============
    // Pins follow the next state so each strobe has its exact width.
    assign dataExt = (state_d == EDAS_DATA) && !internal_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            memAddr <= 16'h0000;
        end else if (state_d == EDAS_FETCH) begin
            memAddr <= pc_q;
        end else if (dataExt) begin
            memAddr <= dataAddr_q;
        end
    end

    // Read and write strobes are gated by direction and the fetch strobe by state, so they can never overlap.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            memRdN    <= 1'b1;
            memWrN    <= 1'b1;
            memFetchN <= 1'b1;
        end else begin
            memRdN    <= !(dataExt && !wrDir_q &&
                           inStrobe(cnt_d, stretch_q));
            memWrN    <= !(dataExt && wrDir_q &&
                           inStrobe(cnt_d, stretch_q));
            memFetchN <= !((state_d == EDAS_FETCH) &&
                           (cnt_d >= FETCH_STRB_FRST) &&
                           (cnt_d <= FETCH_STRB_LAST));
        end
    end

    // Write data is driven from strobe start to the end of the hold.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            memDataOut <= BYTE_ZERO;
            memDataOe  <= 1'b0;
        end else begin
            memDataOut <= wdata_q;
            memDataOe  <= dataExt && wrDir_q &&
                          (cnt_d >= strobeSetup(stretch_q));
        end
    end

endmodule : edas_top

// ### bench/edas_top_assertions.sv
// Checker for the external data access block: strobe shapes and timing.
// Assumes it is bound to edas_top and sees only the ports it lists.
module edas_checker
    import edas_pkg::*;
(
    input wire logic        clk,        // Oscillator clock.
    input wire logic        resetn,     // Async reset, active low.
    input wire logic [7:0]  regAddr,    // Register address.
    input wire logic [7:0]  regWdata,   // Register write data.
    input wire logic        regWrite,   // Register write strobe.
    input wire logic        reqValid,   // Request pulse.
    input wire logic        reqMove,    // Data move requested.
    input wire logic [15:0] reqPc,      // Fetch address.
    input wire logic [7:0]  reqWdata,   // Data to write.
    input wire logic        busy,       // Access in progress.
    input wire logic        done,       // Access finished.
    input wire logic [15:0] memAddr,    // Address pins.
    input wire logic [7:0]  memDataOut, // Data pins, output.
    input wire logic        memDataOe,  // Data drive enable.
    input wire logic        memRdN,     // Read strobe.
    input wire logic        memWrN,     // Write strobe.
    input wire logic        memFetchN   // Fetch strobe.
);
    timeunit 1ns;
    timeprecision 100ps;
    // ============
    // Shadow of the stretch field and of the accepted request
    // ============
    logic [2:0]  stretch_q, latS_q;
    logic        move_q;
    logic [15:0] pc_q;
    logic [7:0]  wd_q;
    logic [4:0]  strbCnt_q;
    logic [5:0]  age_q;
    logic        strb;
    logic [4:0]  expWidth;
    logic [5:0]  expTotal;

    // Expected figures follow the stretch latched with the request.
    assign strb     = !memRdN || !memWrN;
    assign expWidth = (latS_q == 3'h0) ? 5'h02 : {latS_q, 2'h0};
    assign expTotal = {{1'b0, latS_q} + 4'h2, 2'h0} - 6'h01;

    // The stretch is sampled when a request is taken, never mid-access.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stretch_q <= CLK_CTRL_RESET[2:0];
            latS_q    <= CLK_CTRL_RESET[2:0];
            move_q    <= 1'b0;
            pc_q      <= 16'h0000;
            wd_q      <= 8'h00;
        end else begin
            if (regWrite && regAddr == ADDR_CLK_CTRL) begin
                stretch_q <= regWdata[2:0];
            end
            if (reqValid && !busy) begin
                latS_q <= stretch_q;
                move_q <= reqMove;
                pc_q   <= reqPc;
                wd_q   <= reqWdata;
            end
        end
    end

    // Strobe length and the age since the fetch strobe fell.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strbCnt_q <= 5'h00;
            age_q     <= 6'h00;
        end else begin
            strbCnt_q <= strb ? strbCnt_q + 5'h01 : 5'h00;
            age_q     <= $fell(memFetchN) ? 6'h01 : age_q + 6'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_noOverlap; !(!memRdN && !memWrN); endproperty
    a_noOverlap: assert property (p_noOverlap)
        else $error("read and write strobes overlap");
    property p_fetchQuiet; !memFetchN |-> memRdN && memWrN; endproperty
    a_fetchQuiet: assert property (p_fetchQuiet)
        else $error("data strobe during fetch");
    property p_fetchWidth;
        $fell(memFetchN) |=> !memFetchN ##1 memFetchN;
    endproperty
    a_fetchWidth: assert property (p_fetchWidth)
        else $error("fetch strobe width wrong");
    property p_strbWidth; $fell(strb) |-> strbCnt_q == expWidth; endproperty
    a_strbWidth: assert property (p_strbWidth)
        else $error("data strobe width wrong");
    property p_setup;
        $rose(strb) |-> ((latS_q == 3'h0)
            ? ($past(memFetchN, 5) && !$past(memFetchN, 4))
            : ($past(memFetchN, 6) && !$past(memFetchN, 5)));
    endproperty
    a_setup: assert property (p_setup)
        else $error("address to strobe setup wrong");
    property p_total; done |-> age_q == (move_q ? expTotal : 6'h03);
    endproperty
    a_total: assert property (p_total)
        else $error("access length wrong");
    property p_addrStable; strb && $past(strb) |-> $stable(memAddr);
    endproperty
    a_addrStable: assert property (p_addrStable)
        else $error("address moved during strobe");
    property p_writeDrive; !memWrN |-> memDataOe && memDataOut == wd_q;
    endproperty
    a_writeDrive: assert property (p_writeDrive)
        else $error("write data not driven");
    property p_fetchAddr; $fell(memFetchN) |-> memAddr == pc_q; endproperty
    a_fetchAddr: assert property (p_fetchAddr)
        else $error("fetch address wrong");
endmodule : edas_checker

bind edas_top edas_checker edas_checker_i (
    .clk, .resetn, .regAddr, .regWdata, .regWrite, .reqValid, .reqMove,
    .reqPc, .reqWdata, .busy, .done, .memAddr, .memDataOut, .memDataOe,
    .memRdN, .memWrN, .memFetchN
);

// ### bench/edas_sram_model.sv
// Behavioural external SRAM on the data bus with a chosen access delay.
// Assumes active low strobes and a data bus with no pull resistor.
module edas_sram_model (
    input  wire logic        clk,        // Oscillator clock.
    input  wire logic        resetn,     // Async reset, active low.
    input  wire logic [15:0] memAddr,    // Address pins.
    input  wire logic [7:0]  memDataOut, // Write data from the block.
    input  wire logic        memRdN,     // Read strobe, active low.
    input  wire logic        memWrN,     // Write strobe, active low.
    input  wire logic        memFetchN,  // Fetch strobe, active low.
    input  wire logic [4:0]  accessClks, // Strobe clocks before data valid.
    output logic      [7:0]  memDataIn,  // Data towards the block.
    output logic      [15:0] addrSeen    // Address of the last read or write strobe.
);
    timeunit 1ns;
    timeprecision 100ps;
    // ============
    // Storage and access delay
    // ============
    logic [7:0] mem [256];
    logic [7:0] last_q;
    logic [4:0] age_q;

    // A released bus shows the inverse of its last value, so an early
    // sample can never match by luck.
    assign memDataIn = (!memFetchN || (!memRdN && age_q >= accessClks))
                     ? mem[memAddr[7:0]] : ~last_q;

    // Writes land only once the target has had its access time.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_q   <= 8'h00;
            age_q    <= 5'h00;
            addrSeen <= 16'h0000;
        end else begin
            last_q <= memDataIn;
            age_q  <= (!memRdN || !memWrN) ? age_q + 5'h01 : 5'h00;
            if (!memRdN || !memWrN) begin
                addrSeen <= memAddr;
            end
            if (!memWrN && age_q >= accessClks) begin
                mem[memAddr[7:0]] <= memDataOut;
            end
        end
    end
endmodule : edas_sram_model

// ### bench/tb_external_data_access_stretch.sv
// Self-checking bench for the external data access stretch block.
// Assumes edas_top with the SRAM model on its data bus and a bound checker.
module tb_external_data_access_stretch
    import edas_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ============
    // Signals, design and far side
    // ============
    logic        clk = 1'b0, resetn, regWrite, regRead, reqValid, reqMove;
    logic        reqWriteDir, reqIndirect, busy, done, internalHit;
    logic        memDataOe, memRdN, memWrN, memFetchN;
    logic [7:0]  regAddr, regWdata, regRdata, reqRi, reqWdata, fetchData;
    logic [7:0]  readData, memDataIn, memDataOut;
    logic [15:0] reqPc, memAddr, addrSeen;
    logic [4:0]  accessClks;
    int          failures, compares;

    edas_top edas_top_i (
        .clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
        .reqValid, .reqMove, .reqWriteDir, .reqIndirect, .reqPc, .reqRi,
        .reqWdata, .busy, .done, .fetchData, .readData, .internalHit,
        .memAddr, .memDataIn, .memDataOut, .memDataOe, .memRdN, .memWrN,
        .memFetchN
    );
    edas_sram_model edas_sram_model_i (
        .clk, .resetn, .memAddr, .memDataOut, .memRdN, .memWrN, .accessClks,
        .memFetchN, .memDataIn, .addrSeen
    );

    // Half period of 2.5 ns gives the 200 MHz oscillator.
    always #2.5 clk = ~clk;

    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : checkVal

    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : regWr

    // Read data stand only in the cycle after the strobe.
    task automatic regRd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        checkVal({8'h00, regRdata}, {8'h00, exp});
    endtask : regRd

    // A hang past the bound is counted and closes the run.
    task automatic access(input logic mv, wr, ind, input logic [15:0] pc,
                          input logic [7:0] ri, wd);
        int n;
        @(posedge clk);
        reqValid    <= 1'b1;
        reqMove     <= mv;
        reqWriteDir <= wr;
        reqIndirect <= ind;
        reqPc       <= pc;
        reqRi       <= ri;
        reqWdata    <= wd;
        @(posedge clk);
        reqValid <= 1'b0;
        for (n = 0; n < 200 && done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (done !== 1'b1) begin
            failures++;
            give_verdict();
        end
    endtask : access

    // ============
    // Main sequence
    // ============
    initial begin
        {resetn, regWrite, regRead, reqValid, reqMove} = 5'h00;
        {reqWriteDir, reqIndirect, regAddr, regWdata} = 18'h0;
        {reqRi, reqWdata, reqPc, accessClks} = 37'h0;
        failures = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        regRd(ADDR_CLK_CTRL, CLK_CTRL_RESET);
        regRd(ADDR_PORT2, PORT2_RESET);
        regRd(8'h55, BYTE_ZERO);
        regWr(ADDR_PTR_SEL, 8'hFF);
        regRd(ADDR_PTR_SEL, 8'h01);
        regWr(ADDR_PTR0_LOW, 8'h34);
        regWr(ADDR_PTR0_HIGH, 8'h12);
        regWr(ADDR_PTR1_LOW, 8'h78);
        regWr(ADDR_PTR1_HIGH, 8'h56);
        access(1'b1, 1'b1, 1'b0, 16'h0010, 8'h00, 8'h5A);
        checkVal(addrSeen, 16'h5678);
        // Every stretch value, alternating pointers from one stretch value to the next.
        for (int s = 0; s < 8; s++) begin
            regWr(ADDR_CLK_CTRL, {5'h00, s[2:0]});
            regWr(ADDR_PTR_SEL, {7'h00, s[0]});
            access(1'b1, 1'b1, 1'b0, 16'h0100, 8'h00, 8'hA0 + 8'(s));
            checkVal(addrSeen, s[0] ? 16'h5678 : 16'h1234);
            access(1'b1, 1'b0, 1'b0, 16'h0102, 8'h00, 8'h00);
            checkVal({8'h00, readData}, 16'h00A0 + 16'(s));
        end
        checkVal({15'h0000, internalHit}, 16'h0000);
        regRd(ADDR_STATUS, BYTE_ZERO);
        // Slow target served by a longer stretch through the page register.
        regWr(ADDR_CLK_CTRL, 8'hFA);
        regRd(ADDR_CLK_CTRL, 8'hFA);
        regWr(ADDR_PORT2, 8'h3C);
        accessClks <= 5'h06;
        access(1'b1, 1'b1, 1'b1, 16'h0200, 8'h5A, 8'hC3);
        checkVal(addrSeen, 16'h3C5A);
        access(1'b1, 1'b0, 1'b1, 16'h0202, 8'h5A, 8'h00);
        checkVal({8'h00, readData}, 16'h00C3);
        regWr(ADDR_CLK_CTRL, 8'h07);
        access(1'b0, 1'b0, 1'b0, 16'hAB5A, 8'h00, 8'h00);
        checkVal({8'h00, fetchData}, 16'h00C3);
        // Reset in mid-run restores the default stretch and pointers.
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        regRd(ADDR_CLK_CTRL, CLK_CTRL_RESET);
        access(1'b1, 1'b1, 1'b0, 16'h0300, 8'h00, 8'h11);
        checkVal(addrSeen, 16'h0000);
        give_verdict();
    end
endmodule : tb_external_data_access_stretch
